// ---- hw/iblr_bus_lock_recovery.sv ----
// Summary of operation
// - Output data bit 11 high pulls the clock line of bus 1 low, bit 11 low releases it.
// - Output data bit 10 high pulls the clock line of bus 0 low, bit 10 low releases it.
// - Bits 11 and 10 of the output data word are writable by software.
// - The serial unit sees the bus busy while the clock is high and the data line is low.
// - The serial unit ignores the internal bus processor reset, so a held bus stays locked.
module iblr_bus_lock_recovery
  import iblr_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic link_clk,
  input wire logic link_resetn,
  input wire logic gpo_write,
  input wire logic [IBLR_GPO_WIDTH-1:0] gpo_wdata,
  input wire logic [1:0] scl_i,
  input wire logic [1:0] sda_i,
  output logic [1:0] scl_o,
  output logic [1:0] scl_oe_n,
  output logic [1:0] general_output_data_bits,
  output logic [1:0] bus_busy
);

  iblr_core_t core;
  iblr_core_t next_core;
  iblr_link_t link;
  iblr_link_t next_link;

  // Busy tracking per bus
  function automatic logic busy_update(input logic busy, input logic scl,
                                       input logic sda, input logic sda_prev);
    logic result;
    result = busy;
    if (scl && !sda_prev && sda) begin
      result = 1'b0;
    end
    if (scl && sda_prev && !sda) begin
      result = 1'b1;
    end
    if (scl && !sda) begin
      result = 1'b1;
    end
    return result;
  endfunction

  // Processor domain: forcing bits and open-drain controls
  always_comb begin
    next_core = core;
    if (gpo_write) begin
      next_core.force_low[1] = gpo_wdata[IBLR_SCL1_BIT];
      next_core.force_low[0] = gpo_wdata[IBLR_SCL0_BIT];
    end
    next_core.scl_level = IBLR_DRIVE_LEVEL;
    next_core.scl_oe_n[1] = ~next_core.force_low[1];
    next_core.scl_oe_n[0] = ~next_core.force_low[0];
    next_core.busy_m = link.busy;
    next_core.busy_s = core.busy_m;
    next_core.busy = core.busy_s;
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      core.force_low <= IBLR_FORCE_RST;
      core.scl_level <= IBLR_DRIVE_LEVEL;
      core.scl_oe_n <= IBLR_OE_N_RST;
      core.busy_m <= IBLR_BUSY_RST;
      core.busy_s <= IBLR_BUSY_RST;
      core.busy <= IBLR_BUSY_RST;
    end else begin
      core <= next_core;
    end
  end

  // Serial unit domain, reset only at power-on
  always_comb begin
    next_link = link;
    next_link.scl_m = scl_i;
    next_link.scl_s = link.scl_m;
    next_link.sda_m = sda_i;
    next_link.sda_s = link.sda_m;
    next_link.sda_prev = link.sda_s;
    for (int b = 0; b < IBLR_NUM_BUS; b++) begin
      next_link.busy[b] = busy_update(link.busy[b], link.scl_s[b],
                                      link.sda_s[b], link.sda_prev[b]);
    end
  end

  always_ff @(posedge link_clk) begin
    if (!link_resetn) begin
      link.scl_m <= IBLR_PIN_RST;
      link.scl_s <= IBLR_PIN_RST;
      link.sda_m <= IBLR_PIN_RST;
      link.sda_s <= IBLR_PIN_RST;
      link.sda_prev <= IBLR_PIN_RST;
      link.busy <= IBLR_BUSY_RST;
    end else begin
      link <= next_link;
    end
  end

  assign scl_o = core.scl_level;
  assign scl_oe_n = core.scl_oe_n;
  assign general_output_data_bits = core.force_low;
  assign bus_busy = core.busy;

endmodule // iblr_bus_lock_recovery

// ---- hw/iblr_pkg.sv ----
package iblr_pkg;

  localparam int IBLR_NUM_BUS = 2;
  localparam int IBLR_GPO_WIDTH = 32;
  localparam int IBLR_SCL0_BIT = 10;
  localparam int IBLR_SCL1_BIT = 11;
  localparam logic [1:0] IBLR_FORCE_RST = 2'h0;
  localparam logic [1:0] IBLR_OE_N_RST = 2'h3;
  localparam logic [1:0] IBLR_DRIVE_LEVEL = 2'h0;
  localparam logic [1:0] IBLR_BUSY_RST = 2'h0;
  localparam logic [1:0] IBLR_PIN_RST = 2'h3;

  typedef struct packed {
    logic [1:0] force_low;
    logic [1:0] scl_level;
    logic [1:0] scl_oe_n;
    logic [1:0] busy_m;
    logic [1:0] busy_s;
    logic [1:0] busy;
  } iblr_core_t;

  typedef struct packed {
    logic [1:0] scl_m;
    logic [1:0] scl_s;
    logic [1:0] sda_m;
    logic [1:0] sda_s;
    logic [1:0] sda_prev;
    logic [1:0] busy;
  } iblr_link_t;

endpackage

// ---- tb/iblr_bus_lock_recovery_bench.sv ----
module iblr_bus_lock_recovery_bench;
  import iblr_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, lclk = 0, resetn = 0, lrn = 0, wr = 0, lock = 0;
  logic [31:0] wd = 0, r = 32'h28acd466;
  logic [1:0] oe, so, gb, bb, sda;
  wire [1:0] scl = oe | so;
  int err_count, tests_run, i;
  initial forever #12.5 clk = ~clk;
  initial #7 forever #24 lclk = ~lclk;
  iblr_bus_lock_recovery i_dut(.clk(clk), .resetn(resetn), .link_clk(lclk),
    .link_resetn(lrn), .gpo_write(wr), .gpo_wdata(wd), .scl_i(scl), .sda_i(sda),
    .scl_o(so), .scl_oe_n(oe), .general_output_data_bits(gb), .bus_busy(bb));
  iblr_slave i_sl[1:0](.scl(scl), .lock(lock), .sda(sda));
  function automatic logic [31:0] lfsr(logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(logic [1:0] s, logic [1:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t saw %b want %b", $time, s, e);
    end
  endtask
  task automatic put(logic [31:0] v);
    @(negedge clk) wr = 1;
    wd = v;
    @(negedge clk) wr = 0;
    chk(gb, v[11:10]);
    chk(oe, ~v[11:10]);
    chk(so, 2'h0);
  endtask
  task automatic wait_busy(logic [1:0] e);
    for (i = 0; i < 40 && bb !== e; i++) @(negedge clk);
    chk(bb, e);
    if (bb !== e) results;
  endtask
  task automatic results;
    $display("mismatches %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (3) @(negedge clk);
    resetn = 1;
    lrn = 1;
    chk(oe, IBLR_OE_N_RST);
    repeat (20) begin
      r = lfsr(r);
      put(r);
    end
    put(0);
    lock = 1;
    @(negedge clk) lock = 0;
    wait_busy(2'h3);
    resetn = 0;
    @(negedge clk) resetn = 1;
    wait_busy(2'h3);
    repeat (8) begin
      put(32'hc00);
      repeat (6) @(negedge clk);
      put(0);
      repeat (6) @(negedge clk);
    end
    wait_busy(2'h0);
    results;
  end
endmodule // iblr_bus_lock_recovery_bench

// ---- tb/iblr_properties.sv ----
module iblr_properties
  import iblr_pkg::*;
(
  input wire logic clk, resetn, link_resetn, gpo_write,
  input wire logic [IBLR_GPO_WIDTH-1:0] gpo_wdata,
  input wire logic [1:0] scl_i, sda_i, scl_o, scl_oe_n, general_output_data_bits, bus_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn || !link_resetn);
  AST_SCL1: assert property (gpo_write |=> scl_oe_n[1] != $past(gpo_wdata[11]))
    else $error("bus 1 pull");
  AST_SCL0: assert property (gpo_write |=> scl_oe_n[0] != $past(gpo_wdata[10]))
    else $error("bus 0 pull");
  AST_RDBK: assert property (gpo_write |=> general_output_data_bits == $past(gpo_wdata[11:10]))
    else $error("readback");
  AST_HOLD: assert property (!gpo_write |=> $stable(scl_oe_n))
    else $error("pull moved");
  AST_DRAIN: assert property (scl_o == IBLR_DRIVE_LEVEL)
    else $error("drives high");
  AST_BUSY: assert property ((scl_i[0] && !sda_i[0]) [*8] |-> ##[0:6] bus_busy[0])
    else $error("no busy");
  cover property (gpo_write && gpo_wdata[11]);
  cover property (bus_busy == 2'h3);
  cover property ($fell(bus_busy[0]));
endmodule // iblr_properties
bind iblr_bus_lock_recovery iblr_properties i_prop(.*);

// ---- tb/iblr_slave.sv ----
module iblr_slave(input wire logic scl, input wire logic lock, output logic sda);
  timeunit 1ns;
  timeprecision 1ns;
  int n = 8;
  always @(posedge scl or posedge lock) n <= lock ? 0 : (n < 8 ? n + 1 : n);
  assign sda = n >= 8;
endmodule // iblr_slave
